// ### hdl/stc_pkg.sv
// Register map, field positions, reset values and mode codes of the standard timer
package stc_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] STC_ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] STC_ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] STC_ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] STC_ADDR_CNT_HI = 8'h0c;
  localparam logic [7:0] STC_ADDR_CA_LO  = 8'h10;
  localparam logic [7:0] STC_ADDR_CA_HI  = 8'h14;
  localparam logic [7:0] STC_ADDR_CP     = 8'h18;
  localparam logic [7:0] STC_ADDR_FLAGS  = 8'h1c;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STC_CA_PAUSE   = 7;
  localparam int STC_CA_CK_HI   = 6;
  localparam int STC_CA_CK_LO   = 4;
  localparam int STC_CA_ON      = 3;
  localparam int STC_CB_MODE_HI = 7;
  localparam int STC_CB_MODE_LO = 6;
  localparam int STC_CB_IO_HI   = 5;
  localparam int STC_CB_IO_LO   = 4;
  localparam int STC_CB_OC      = 3;
  localparam int STC_CB_POL     = 2;
  localparam int STC_CB_DPX     = 1;
  localparam int STC_CB_CCLR    = 0;
  localparam int STC_FLAG_A     = 0;
  localparam int STC_FLAG_P     = 1;
  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  STC_RST_CTRL_A = 8'h00;
  localparam logic [7:0]  STC_RST_CTRL_B = 8'h00;
  localparam logic [15:0] STC_RST_WORD   = 16'h0000;
  localparam logic [7:0]  STC_RST_BYTE   = 8'h00;
  localparam logic [7:0]  STC_CTRL_A_MASK = 8'hf8;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int STC_SYS_CLOCK_HZ = 25_000_000;
  localparam int STC_SUB_CLOCK_HZ = 32_768;
  localparam int STC_SUB_DIV = (STC_SYS_CLOCK_HZ + STC_SUB_CLOCK_HZ / 2) / STC_SUB_CLOCK_HZ;
  // ----------------------------------------------------------------
  // Mode, clock and pin function codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    STC_MODE_COMPARE = 2'b00, STC_MODE_CAPTURE = 2'b01,
    STC_MODE_PWM     = 2'b10, STC_MODE_TIMER   = 2'b11
  } stc_mode_t;
  typedef enum logic [2:0] {
    STC_CLK_SYS4  = 3'b000, STC_CLK_SYS    = 3'b001,
    STC_CLK_HI16  = 3'b010, STC_CLK_HI64   = 3'b011,
    STC_CLK_SUB_A = 3'b100, STC_CLK_SUB_B  = 3'b101,
    STC_CLK_EXT_R = 3'b110, STC_CLK_EXT_F  = 3'b111
  } stc_clk_t;
  localparam logic [1:0] STC_IO_CMP_LOW  = 2'h1;
  localparam logic [1:0] STC_IO_CMP_HIGH = 2'h2;
  localparam logic [1:0] STC_IO_CMP_TGL  = 2'h3;
  localparam logic [1:0] STC_IO_PWM_OFF  = 2'h0;
  localparam logic [1:0] STC_IO_PWM_ON   = 2'h1;
  localparam logic [1:0] STC_IO_PWM_WAVE = 2'h2;
  localparam logic [1:0] STC_IO_PULSE    = 2'h3;
  localparam logic [1:0] STC_IO_CAP_RISE = 2'h0;
  localparam logic [1:0] STC_IO_CAP_FALL = 2'h1;
  localparam logic [1:0] STC_IO_CAP_BOTH = 2'h2;
endpackage

// ### hdl/stc_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module stc_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Pin and filtered result
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
    logic       rise;
    logic       fall;
  } stc_sync_t;
  stc_sync_t s;
  stc_sync_t next_s;
  always_comb begin
    next_s = s;
    next_s.sh = {s.sh[1:0], pin};
    next_s.rise = 1'h0;
    next_s.fall = 1'h0;
    // Stage one feeds only stage two; the filter looks at stages two and three
    if (s.sh[1] == s.sh[2]) begin
      next_s.lvl = s.sh[2];
      next_s.rise = s.sh[2] & ~s.lvl;
      next_s.fall = ~s.sh[2] & s.lvl;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign level = s.lvl;
  assign rise = s.rise;
  assign fall = s.fall;
endmodule // stc_sync

// ### hdl/stc_prescale.sv
// Clock enable divider for the internal counter clock choices
`timescale 1ns/1ps
module stc_prescale #(
  parameter int SUB_DIV = stc_pkg::STC_SUB_DIV
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // One-cycle enables
  output logic      en_div4,
  output logic      en_div16,
  output logic      en_div64,
  output logic      en_sub
);
  typedef struct packed {
    logic [5:0] fast;
    logic [9:0] sub;
  } stc_pre_t;
  stc_pre_t s;
  stc_pre_t next_s;
  // The sub divider counter is ten bits wide
  if (SUB_DIV < 2 || SUB_DIV > 1024) begin : g_bad_div
    $error("SUB_DIV out of range");
  end
  always_comb begin
    next_s = s;
    next_s.fast = s.fast + 6'h01;
    if (s.sub == 10'(SUB_DIV - 1)) begin
      next_s.sub = 10'h000;
    end else begin
      next_s.sub = s.sub + 10'h001;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  // High clock is taken as the system clock here
  assign en_div4 = (s.fast[1:0] == 2'h3);
  assign en_div16 = (s.fast[3:0] == 4'hf);
  assign en_div64 = (s.fast == 6'h3f);
  assign en_sub = (s.sub == 10'(SUB_DIV - 1));
endmodule // stc_prescale

// ### hdl/stc_top.sv
// Standard timer: control registers, 16-bit counter, compare, capture and PWM output
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// How it works
// - Pause bit freezes the counter; clearing it resumes from the held value.
// - Clock select picks sys/4, sys, high/16, high/64, sub, or external edge.
// - On bit rising clears counter and starts; falling stops and keeps count.
// - On bit rising returns the output pin to its initial level.
// - Low three bits of control A read zero and ignore writes.
// - Mode field selects compare, capture, PWM/single pulse or timer.
// - Compare mode: A match leaves, lowers, raises or toggles the output.
// - PWM mode: forced inactive, forced active, PWM wave or single pulse.
// - Capture mode: capture on rising, falling, both edges, or disabled.
// - Timer mode: pin unused; output control and polarity have no effect.
// - A match requesting the level already present leaves the pin unchanged.
// - Compare mode: output control gives the level before any match.
// - PWM: output control picks active level; single pulse: level at start.
// - Polarity bit inverts the output pin except in timer mode.
// - Swap bit exchanges the period and duty roles of the two compares.
// - Clear on A match when set; else on P match or overflow.
// - Clear select is ignored in PWM, single pulse and capture modes.
// - Counter is a read-only byte pair; compare A is 16-bit, P 8-bit.
// - P compares with counter upper byte; A compares all sixteen bits.
// - Low bytes pass a shared buffer loaded on high byte reads and low byte writes.
// - With clear select set in compare or timer mode only the A flag is raised, never P.
// ------------------------------------------------------------------
module stc_top #(
  parameter int SUB_DIV = stc_pkg::STC_SUB_DIV
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        ext_clock_pin,
  input  wire logic        capture_input_pin,
  output logic             timer_output_pin,
  output logic             timer_output_en,
  // Event flags
  output logic             compare_a_flag,
  output logic             compare_p_flag
);
  import stc_pkg::*;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [15:0] count;
    logic [15:0] ca;
    logic [7:0]  cp;
    logic [7:0]  buffer;
    logic        flag_a;
    logic        flag_p;
    logic        on_d;
    logic        out_lvl;
    logic        pulse_done;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        pin_en;
  } stc_state_t;
  stc_state_t s;
  stc_state_t next_s;
  logic [1:0]  rst_pipe;
  logic        rst_sync;
  logic        en_div4;
  logic        en_div16;
  logic        en_div64;
  logic        en_sub;
  logic        ext_rise;
  logic        ext_fall;
  logic        cap_rise;
  logic        cap_fall;
  logic        on;
  logic        on_rise;
  logic        tick;
  logic        run;
  logic        hit_a;
  logic        hit_p;
  logic        hit_period;
  logic        hit_duty;
  logic        clear;
  logic        cap_evt;
  logic        active;
  logic        raw;
  logic        setup;
  logic        acc;
  logic [15:0] inc;
  logic [15:0] period;
  logic [15:0] duty;
  stc_mode_t   mode;
  logic [1:0]  io;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic stc_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= STC_ADDR_FLAGS);
  endfunction
  // ----------------------------------------------------------------
  // Reset release and submodules
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end
  assign rst_sync = rst_pipe[1];
  stc_prescale #(.SUB_DIV(SUB_DIV)) u_pre (
    .clock    (clock),
    .rst_n    (rst_sync),
    .en_div4  (en_div4),
    .en_div16 (en_div16),
    .en_div64 (en_div64),
    .en_sub   (en_sub)
  );
  // External clock passes the synchroniser before edge use
  stc_sync u_ext (
    .clock (clock),
    .rst_n (rst_sync),
    .pin   (ext_clock_pin),
    .level (),
    .rise  (ext_rise),
    .fall  (ext_fall)
  );
  stc_sync u_cap (
    .clock (clock),
    .rst_n (rst_sync),
    .pin   (capture_input_pin),
    .level (),
    .rise  (cap_rise),
    .fall  (cap_fall)
  );
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    on = s.ctrl_a[STC_CA_ON];
    on_rise = on & ~s.on_d;
    mode = stc_mode_t'(s.ctrl_b[STC_CB_MODE_HI:STC_CB_MODE_LO]);
    io = s.ctrl_b[STC_CB_IO_HI:STC_CB_IO_LO];
    case (stc_clk_t'(s.ctrl_a[STC_CA_CK_HI:STC_CA_CK_LO]))
      STC_CLK_SYS4: tick = en_div4;
      STC_CLK_SYS: tick = 1'h1;
      STC_CLK_HI16: tick = en_div16;
      STC_CLK_HI64: tick = en_div64;
      STC_CLK_SUB_A, STC_CLK_SUB_B: tick = en_sub;
      STC_CLK_EXT_R: tick = ext_rise;
      STC_CLK_EXT_F: tick = ext_fall;
      default: tick = 1'h0;
    endcase
    run = on & ~s.ctrl_a[STC_CA_PAUSE] & ~on_rise & tick;
    inc = s.count + 16'h0001;
    // A compares all bits, P the upper byte with the low byte of the next count zero
    hit_a = run & (inc == s.ca) & (s.ca != STC_RST_WORD);
    hit_p = run & (inc[15:8] == s.cp) & (inc[7:0] == 8'h00);
    // Swap bit exchanges period and duty
    period = s.ctrl_b[STC_CB_DPX] ? s.ca : {s.cp, 8'h00};
    duty = s.ctrl_b[STC_CB_DPX] ? {s.cp, 8'h00} : s.ca;
    hit_period = run & (inc == period);
    hit_duty = run & (inc == duty);
    case (mode)
      // Clear select only matters in compare and timer modes
      STC_MODE_PWM: clear = hit_period;
      STC_MODE_CAPTURE: clear = hit_p;
      default: clear = s.ctrl_b[STC_CB_CCLR] ? hit_a : hit_p;
    endcase
    case (io)
      STC_IO_CAP_RISE: cap_evt = cap_rise;
      STC_IO_CAP_FALL: cap_evt = cap_fall;
      STC_IO_CAP_BOTH: cap_evt = cap_rise | cap_fall;
      default: cap_evt = 1'h0;
    endcase
    cap_evt = cap_evt & on & (mode == STC_MODE_CAPTURE);
    // Counter
    next_s.on_d = on;
    if (on_rise) begin
      next_s.count = STC_RST_WORD;
      next_s.out_lvl = s.ctrl_b[STC_CB_OC];
      next_s.pulse_done = 1'h0;
    end else if (run) begin
      next_s.count = clear ? STC_RST_WORD : inc;
      if (hit_duty) begin
        next_s.pulse_done = 1'h1;
      end
    end
    // Compare output action; a level equal to the present one changes nothing
    if (hit_a && mode == STC_MODE_COMPARE && !on_rise) begin
      case (io)
        STC_IO_CMP_LOW: next_s.out_lvl = 1'h0;
        STC_IO_CMP_HIGH: next_s.out_lvl = 1'h1;
        STC_IO_CMP_TGL: next_s.out_lvl = ~s.out_lvl;
        default: next_s.out_lvl = s.out_lvl;
      endcase
    end
    // Waveform
    case (io)
      STC_IO_PWM_OFF: active = 1'h0;
      STC_IO_PWM_ON: active = 1'h1;
      STC_IO_PWM_WAVE: active = on & (s.count < duty);
      default: active = on & ~s.pulse_done;
    endcase
    if (mode == STC_MODE_PWM) begin
      raw = active ? s.ctrl_b[STC_CB_OC] : ~s.ctrl_b[STC_CB_OC];
    end else begin
      raw = s.out_lvl;
    end
    // Timer mode leaves the pin undriven
    next_s.pin = (mode == STC_MODE_TIMER) ? 1'h0 : raw ^ s.ctrl_b[STC_CB_POL];
    next_s.pin_en = (mode == STC_MODE_COMPARE) || (mode == STC_MODE_PWM);
    // APB; one access cycle, pready rises in the first access cycle
    setup = psel & ~penable;
    acc = psel & penable & s.pready;
    next_s.pready = setup;
    if (setup) begin
      next_s.pslverr = ~stc_mapped(paddr);
      next_s.prdata = 32'h0000_0000;
      case (paddr)
        STC_ADDR_CTRL_A: next_s.prdata[7:0] = s.ctrl_a;
        STC_ADDR_CTRL_B: next_s.prdata[7:0] = s.ctrl_b;
        STC_ADDR_CNT_HI: next_s.prdata[7:0] = s.count[15:8];
        STC_ADDR_CA_HI: next_s.prdata[7:0] = s.ca[15:8];
        STC_ADDR_CP: next_s.prdata[7:0] = s.cp;
        STC_ADDR_FLAGS: next_s.prdata[1:0] = {s.flag_p, s.flag_a};
        STC_ADDR_CNT_LO, STC_ADDR_CA_LO: next_s.prdata[7:0] = s.buffer;
        default: next_s.prdata = 32'h0000_0000;
      endcase
    end
    next_s.flag_a = s.flag_a;
    next_s.flag_p = s.flag_p;
    if (acc && pwrite && !s.pslverr) begin
      case (paddr)
        STC_ADDR_CTRL_A: next_s.ctrl_a = pwdata[7:0] & STC_CTRL_A_MASK;
        STC_ADDR_CTRL_B: next_s.ctrl_b = pwdata[7:0];
        STC_ADDR_CA_LO: next_s.buffer = pwdata[7:0];
        STC_ADDR_CA_HI: next_s.ca = {pwdata[7:0], s.buffer};
        STC_ADDR_CP: next_s.cp = pwdata[7:0];
        STC_ADDR_FLAGS: begin
          next_s.flag_a = s.flag_a & ~pwdata[STC_FLAG_A];
          next_s.flag_p = s.flag_p & ~pwdata[STC_FLAG_P];
        end
        default: next_s.cp = s.cp;
      endcase
    end
    if (acc && !pwrite && paddr == STC_ADDR_CNT_HI) begin
      next_s.buffer = s.count[7:0];
    end
    if (acc && !pwrite && paddr == STC_ADDR_CA_HI) begin
      next_s.buffer = s.ca[7:0];
    end
    // Capture overrides a software write of compare A in the same cycle
    if (cap_evt) begin
      next_s.ca = s.count;
    end
    // Flag set wins over a clear in the same cycle
    if (hit_a || cap_evt) begin
      next_s.flag_a = 1'h1;
    end
    if (hit_p && !(s.ctrl_b[STC_CB_CCLR] && mode != STC_MODE_PWM
        && mode != STC_MODE_CAPTURE)) begin
      next_s.flag_p = 1'h1;
    end
  end
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      s <= '0;
      s.ctrl_a <= STC_RST_CTRL_A;
      s.ctrl_b <= STC_RST_CTRL_B;
    end else begin
      s <= next_s;
    end
  end
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign timer_output_pin = s.pin;
  assign timer_output_en = s.pin_en;
  assign compare_a_flag = s.flag_a;
  assign compare_p_flag = s.flag_p;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking stc_cb @(posedge clock);
  endclocking
  default disable iff (!rst_sync);
  property p_pause_hold;
    (on && s.on_d && s.ctrl_a[STC_CA_PAUSE]) |=> (s.count == $past(s.count));
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("count moved in pause");
  property p_on_clear;
    on_rise |=> (s.count == 16'h0000);
  endproperty
  a_on_clear: assert property (p_on_clear) else $error("count not cleared");
  property p_off_hold;
    (!on && s.on_d) |=> (s.count == $past(s.count)) [*2];
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("count moved when off");
  property p_init_level;
    (on_rise && mode == STC_MODE_COMPARE)
      |=> (s.out_lvl == $past(s.ctrl_b[STC_CB_OC])) ##1 (s.pin_en == 1'h1);
  endproperty
  a_init_level: assert property (p_init_level) else $error("bad initial level");
  property p_low_bits;
    (acc && !pwrite && paddr == STC_ADDR_CTRL_A) |-> (prdata[2:0] == 3'h0);
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("low bits set");
  property p_cmp_low;
    (hit_a && !on_rise && mode == STC_MODE_COMPARE && io == STC_IO_CMP_LOW)
      |=> !s.out_lvl;
  endproperty
  a_cmp_low: assert property (p_cmp_low) else $error("match did not lower");
  property p_no_pflag;
    (s.ctrl_b[STC_CB_CCLR] && mode == STC_MODE_COMPARE && !s.flag_p) |=> !s.flag_p;
  endproperty
  a_no_pflag: assert property (p_no_pflag) else $error("p flag with clear on a");
  property p_polarity;
    (mode == STC_MODE_PWM && io == STC_IO_PWM_ON)
      |=> (timer_output_pin == ($past(s.ctrl_b[STC_CB_OC]) ^ $past(s.ctrl_b[STC_CB_POL])));
  endproperty
  a_polarity: assert property (p_polarity) else $error("bad forced level");
  property p_buffer;
    (acc && !pwrite && paddr == STC_ADDR_CNT_HI) |=> (s.buffer == $past(s.count[7:0]));
  endproperty
  a_buffer: assert property (p_buffer) else $error("buffer not loaded");
  property p_pclear;
    (mode == STC_MODE_COMPARE && !s.ctrl_b[STC_CB_CCLR] && hit_p && !on_rise)
      |=> (s.count == 16'h0000) && s.flag_p;
  endproperty
  a_pclear: assert property (p_pclear) else $error("p match did not clear");
endmodule // stc_top

// ### bench/stc_pins_model.sv
// Far-side pin model: external count clock bursts and the capture input
`timescale 1ns/1ps
module stc_pins_model (
  // Clock
  input  wire logic       clock,
  // Requests from the bench
  input  wire logic [3:0] burst_len,
  input  wire logic       burst_go,
  input  wire logic       cap_level,
  // Pins towards the timer
  output logic            ext_clock_pin,
  output logic            capture_input_pin
);
  logic [3:0] left;
  logic [2:0] phase;
  initial begin
    left = 4'h0;
    phase = 3'h0;
    ext_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
  end
  // The external clock stands still between bursts; each pulse is 8 cycles high and 8 cycles low
  always @(posedge clock) begin
    phase <= phase + 3'h1;
    capture_input_pin <= cap_level;
    if (burst_go) begin
      left <= burst_len;
      phase <= 3'h0;
    end else if (left != 4'h0 && phase == 3'h7) begin
      ext_clock_pin <= ~ext_clock_pin;
      if (ext_clock_pin) left <= left - 4'h1;
    end
  end
endmodule // stc_pins_model

// ### bench/standard_timer_control_tb.sv
// Self-checking bench for the standard timer
`timescale 1ns/1ps
module standard_timer_control_tb;
  import stc_pkg::*;
  logic clock, rst_n, psel, penable, pwrite, timer_output_pin, timer_output_en;
  logic [7:0] paddr, rdata;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, ext_clock_pin, capture_input_pin, compare_a_flag, compare_p_flag;
  logic burst_go, cap_level, rerr, got;
  logic [3:0] burst_len;
  int failures, compares;
  stc_top #(.SUB_DIV(4)) u_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
    .capture_input_pin(capture_input_pin), .timer_output_pin(timer_output_pin),
    .timer_output_en(timer_output_en), .compare_a_flag(compare_a_flag),
    .compare_p_flag(compare_p_flag));
  stc_pins_model u_pins (.clock(clock), .burst_len(burst_len), .burst_go(burst_go),
    .cap_level(cap_level), .ext_clock_pin(ext_clock_pin),
    .capture_input_pin(capture_input_pin));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, s, tol);
    compares++;
    if ((s + tol >= e && s <= e + tol) !== 1'b1) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Request held until pready is sampled high; read data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdata = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  task automatic rd16(input logic [7:0] hi, output logic [15:0] v);
    rd(hi);
    v[15:8] = rdata;
    rd(hi - 8'h04);
    v[7:0] = rdata;
  endtask
  task automatic wait_flag(input logic p, input int lim);
    got = 1'b0;
    for (int i = 0; i < lim && got !== 1'b1; i++) begin
      @(posedge clock);
      got = p ? compare_p_flag : compare_a_flag;
    end
  endtask
  // Mode changes only ever happen with the timer off
  task automatic setup(input logic [7:0] cb, input logic [15:0] ca, input logic [7:0] cp);
    wr(STC_ADDR_CTRL_A, 8'h00);
    wr(STC_ADDR_CTRL_B, cb);
    wr(STC_ADDR_CA_LO, ca[7:0]);
    wr(STC_ADDR_CA_HI, ca[15:8]);
    wr(STC_ADDR_CP, cp);
    wr(STC_ADDR_FLAGS, 8'h03);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i));
      chk("reset_value", 16'h0, {8'h0, rdata}, 16'h0);
    end
    wr(STC_ADDR_CTRL_A, 8'hf7);
    rd(STC_ADDR_CTRL_A);
    chk("ctrl_a", 16'hf0, {8'h0, rdata}, 16'h0);
    wr(STC_ADDR_CTRL_A, 8'h00);
    wr(STC_ADDR_CNT_HI, 8'hff);
    rd16(STC_ADDR_CNT_HI, v);
    chk("count_ro", 16'h0, v, 16'h0);
    wr(STC_ADDR_CA_LO, 8'h12);
    wr(STC_ADDR_CA_HI, 8'h34);
    rd16(STC_ADDR_CA_HI, v);
    chk("compare_a", 16'h3412, v, 16'h0);
    rd(8'h20);
    chk("unmapped_err", 16'h1, {15'h0, rerr}, 16'h0);
  endtask
  task automatic t_clocks;
    logic [15:0] v;
    int div [6] = '{4, 1, 16, 64, 4, 4};
    setup(8'hc0, 16'h0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(STC_ADDR_CTRL_A, {1'b0, 3'(i), 4'h8});
      repeat (512) @(posedge clock);
      wr(STC_ADDR_CTRL_A, {1'b0, 3'(i), 4'h0});
      rd16(STC_ADDR_CNT_HI, v);
      chk("count_rate", 16'(515 / div[i]), v, 16'h4);
    end
  endtask
  task automatic t_pause;
    logic [15:0] a, b;
    wr(STC_ADDR_CTRL_A, 8'h18);
    repeat (40) @(posedge clock);
    wr(STC_ADDR_CTRL_A, 8'h98);
    rd16(STC_ADDR_CNT_HI, a);
    repeat (30) @(posedge clock);
    rd16(STC_ADDR_CNT_HI, b);
    chk("paused", a, b, 16'h0);
    wr(STC_ADDR_CTRL_A, 8'h18);
    repeat (30) @(posedge clock);
    wr(STC_ADDR_CTRL_A, 8'h10);
    rd16(STC_ADDR_CNT_HI, b);
    chk("resumed", a + 16'd33, b, 16'h4);
    wr(STC_ADDR_CTRL_A, 8'h18);
    rd16(STC_ADDR_CNT_HI, b);
    chk("restart", 16'h4, b, 16'h4);
  endtask
  task automatic t_ext;
    logic [15:0] v;
    for (int i = 6; i < 8; i++) begin
      // The pause scenario leaves the timer on; a fresh rise clears the count
      wr(STC_ADDR_CTRL_A, 8'h00);
      wr(STC_ADDR_CTRL_A, {1'b0, 3'(i), 4'h8});
      burst_len <= 4'h5;
      burst_go <= 1'b1;
      @(posedge clock);
      burst_go <= 1'b0;
      repeat (120) @(posedge clock);
      wr(STC_ADDR_CTRL_A, 8'h00);
      rd16(STC_ADDR_CNT_HI, v);
      chk("ext_count", 16'h5, v, 16'h0);
      chk("timer_pin", 16'h0, {14'h0, timer_output_en, timer_output_pin}, 16'h0);
    end
  endtask
  task automatic t_pmatch;
    setup(8'hc0, 16'h1000, 8'h01);
    wr(STC_ADDR_CTRL_A, 8'h18);
    wait_flag(1'b1, 300);
    chk("p_flag", 16'h1, {15'h0, got}, 16'h0);
    chk("a_flag", 16'h0, {15'h0, compare_a_flag}, 16'h0);
  endtask
  task automatic t_cmp;
    logic [7:0] cb [6] = '{8'h31, 8'h19, 8'h21, 8'h29, 8'h09, 8'h25};
    logic [5:0] bef = 6'b111010;
    logic [5:0] aft = 6'b011101;
    for (int i = 0; i < 6; i++) begin
      setup(cb[i], 16'h0020, 8'h00);
      wr(STC_ADDR_CTRL_A, 8'h18);
      repeat (3) @(posedge clock);
      chk("pin_initial", {15'h0, bef[i]}, {15'h0, timer_output_pin}, 16'h0);
      chk("pin_enable", 16'h1, {15'h0, timer_output_en}, 16'h0);
      wait_flag(1'b0, 60);
      repeat (3) @(posedge clock);
      chk("pin_match", {15'h0, aft[i]}, {15'h0, timer_output_pin}, 16'h0);
      chk("p_flag_off", 16'h0, {15'h0, compare_p_flag}, 16'h0);
    end
  endtask
  task automatic t_pwm;
    logic [7:0] cb [8] = '{8'ha8, 8'ha0, 8'haa, 8'ha9, 8'h88, 8'h98, 8'hb8, 8'hac};
    logic [15:0] ex [8] = '{256, 768, 512, 256, 0, 1024, 64, 768};
    logic [15:0] hi;
    for (int i = 0; i < 8; i++) begin
      setup(cb[i], (i == 2) ? 16'h0200 : 16'h0040, 8'h01);
      wr(STC_ADDR_CTRL_A, 8'h18);
      hi = 16'h0;
      repeat (1024) begin
        @(posedge clock);
        if (timer_output_pin === 1'b1) hi++;
      end
      chk("pwm_high", ex[i], hi, 16'h4);
    end
  endtask
  task automatic t_cap;
    for (int i = 0; i < 4; i++) begin
      setup({2'b01, 2'(i), 4'h0}, 16'h0, 8'h00);
      wr(STC_ADDR_CTRL_A, 8'h18);
      repeat (10) @(posedge clock);
      cap_level <= 1'b1;
      repeat (10) @(posedge clock);
      cap_level <= 1'b0;
      repeat (10) @(posedge clock);
      chk("capture", {15'h0, i != 3}, {15'h0, compare_a_flag}, 16'h0);
    end
  endtask
  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (40000) @(posedge clock);
    failures++;
    report_and_stop();
  end
  initial begin
    {rst_n, psel, penable, pwrite, burst_go, cap_level} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    burst_len = 4'h0;
    failures = 0;
    compares = 0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_regs();
    t_clocks();
    t_pause();
    t_ext();
    t_pmatch();
    t_cmp();
    t_pwm();
    t_cap();
    report_and_stop();
  end
endmodule // standard_timer_control_tb
